//--- verilog/hbm_break_matcher.sv
// hardware break-condition matcher: two channels, sequential mode, wishbone registers
//
// Functional notes
// - all programmed sub-conditions met on an enabled channel request a halt
// - sequential mode halts only when channel two matched before channel one
// - address sub-condition needs bus address equal to the programmed address
// - general address sees data, dma and fetch cycles; fetch address sees fetches only
// - pre option halts before the fetched instruction runs, otherwise after it
// - channel one fetch mode combines only with the delay count
// - channel two fetch mode combines with nothing else
// - direction sub-condition selects read only or write only cycles
// - cycle type is execution, dma or, when unset, every cycle
// - channel one delay combines with any other sub-condition
// - masked bits of address, fetch address and data are not compared
// - long data needs address multiple of four, word multiple of two
// - core may run two or more instructions before it actually stops
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hbm_break_matcher #(
  parameter int unsigned DELAY_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // monitored bus cycles and retired instructions
  input wire hbm_pkg::hbm_bus_s bus_i,
  input wire hbm_pkg::hbm_ret_s ret_i,
  // halt request towards the core
  output logic halt_req_o,
  output logic halt_pre_o,
  output logic irq_o
);
  if (DELAY_W < 1 || DELAY_W > hbm_pkg::DLY_W) begin : g_chk
    $error("hbm_break_matcher: DELAY_W must be 1 to 12");
  end

  // register state
  logic [hbm_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0] c1_addr_r, c1_amask_r, c1_data_r, c1_dmask_r;
  logic [31:0] c2_addr_r, c2_amask_r;
  hbm_pkg::hbm_cfg_s c1_cfg_r, c2_cfg_r;
  logic [hbm_pkg::ST_W-1:0] status_r, status_nxt;
  logic [hbm_pkg::ST_W-1:0] irq_mask_r;
  logic [31:0] c1_last_r, c2_last_r;

  // bus handshake
  logic req, wr_take, mapped;
  logic [31:0] rdata, wmask;

  // channel signals
  logic [1:0] raw_m, fmode, bad, en, pre_cfg;
  logic [1:0] imm_ev, ret_ev, cond_ev, ev;
  logic [1:0] pend_r;
  logic [31:0] pend_addr_r [2];
  logic d_done, d_busy, d_start, d_cancel;
  logic [DELAY_W-1:0] d_left;
  logic armed_r, armed_nxt;
  logic halt, halt_pre;
  logic [1:0] pre_ev;

  function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [31:0] m);
    apply_sel = (old & ~m) | (nw & m);
  endfunction : apply_sel

  // wishbone decode
  assign req = cyc_i && stb_i;
  assign wr_take = req && we_i && ack_o;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  always_comb begin
    mapped = 1'b1;
    rdata = hbm_pkg::RST_VAL;
    if (adr_i == hbm_pkg::REG_CTRL) begin
      rdata = {29'h0, ctrl_r};
    end else if (adr_i == hbm_pkg::REG_C1_ADDR) begin
      rdata = c1_addr_r;
    end else if (adr_i == hbm_pkg::REG_C1_AMASK) begin
      rdata = c1_amask_r;
    end else if (adr_i == hbm_pkg::REG_C1_DATA) begin
      rdata = c1_data_r;
    end else if (adr_i == hbm_pkg::REG_C1_DMASK) begin
      rdata = c1_dmask_r;
    end else if (adr_i == hbm_pkg::REG_C1_CFG) begin
      rdata = {11'h0, c1_cfg_r};
    end else if (adr_i == hbm_pkg::REG_C2_ADDR) begin
      rdata = c2_addr_r;
    end else if (adr_i == hbm_pkg::REG_C2_AMASK) begin
      rdata = c2_amask_r;
    end else if (adr_i == hbm_pkg::REG_C2_CFG) begin
      rdata = {11'h0, c2_cfg_r};
    end else if (adr_i == hbm_pkg::REG_STATUS) begin
      rdata = {28'h0, status_r};
    end else if (adr_i == hbm_pkg::REG_IRQ_MASK) begin
      rdata = {28'h0, irq_mask_r};
    end else if (adr_i == hbm_pkg::REG_DLY_LEFT) begin
      rdata = 32'(d_left);
    end else if (adr_i == hbm_pkg::REG_C1_LAST) begin
      rdata = c1_last_r;
    end else if (adr_i == hbm_pkg::REG_C2_LAST) begin
      rdata = c2_last_r;
    end else begin
      mapped = 1'b0;
    end
  end

  // answer one cycle after the request, drop the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= hbm_pkg::RST_VAL;
    end else begin
      ack_o <= req && mapped && !ack_o && !err_o;
      err_o <= req && !mapped && !ack_o && !err_o;
      dat_o <= (req && mapped && !we_i && !ack_o) ? rdata : hbm_pkg::RST_VAL;
    end
  end

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
    end else if (wr_take && adr_i == hbm_pkg::REG_CTRL && sel_i[0]) begin
      ctrl_r <= dat_i[hbm_pkg::CTRL_W-1:0];
    end
  end

  // channel one comparison values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_addr_r <= hbm_pkg::RST_VAL;
      c1_amask_r <= hbm_pkg::RST_VAL;
      c1_data_r <= hbm_pkg::RST_VAL;
      c1_dmask_r <= hbm_pkg::RST_VAL;
      c1_cfg_r <= '0;
    end else if (wr_take) begin
      if (adr_i == hbm_pkg::REG_C1_ADDR) begin
        c1_addr_r <= apply_sel(c1_addr_r, dat_i, wmask);
      end else if (adr_i == hbm_pkg::REG_C1_AMASK) begin
        c1_amask_r <= apply_sel(c1_amask_r, dat_i, wmask);
      end else if (adr_i == hbm_pkg::REG_C1_DATA) begin
        c1_data_r <= apply_sel(c1_data_r, dat_i, wmask);
      end else if (adr_i == hbm_pkg::REG_C1_DMASK) begin
        c1_dmask_r <= apply_sel(c1_dmask_r, dat_i, wmask);
      end else if (adr_i == hbm_pkg::REG_C1_CFG) begin
        c1_cfg_r <= hbm_pkg::hbm_cfg_s'(21'(apply_sel({11'h0, c1_cfg_r}, dat_i, wmask)));
      end
    end
  end

  // channel two comparison values; data and delay fields stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c2_addr_r <= hbm_pkg::RST_VAL;
      c2_amask_r <= hbm_pkg::RST_VAL;
      c2_cfg_r <= '0;
    end else if (wr_take) begin
      if (adr_i == hbm_pkg::REG_C2_ADDR) begin
        c2_addr_r <= apply_sel(c2_addr_r, dat_i, wmask);
      end else if (adr_i == hbm_pkg::REG_C2_AMASK) begin
        c2_amask_r <= apply_sel(c2_amask_r, dat_i, wmask);
      end else if (adr_i == hbm_pkg::REG_C2_CFG) begin
        c2_cfg_r <= hbm_pkg::hbm_cfg_s'(21'(apply_sel({11'h0, c2_cfg_r}, dat_i, wmask)));
        c2_cfg_r.dsz <= hbm_pkg::DSZ_NONE;
        c2_cfg_r.delay <= '0;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (wr_take && adr_i == hbm_pkg::REG_IRQ_MASK && sel_i[0]) begin
      irq_mask_r <= dat_i[hbm_pkg::ST_W-1:0];
    end
  end

  // comparators
  hbm_chan_match #(.HAS_DATA(1'b1)) u_ch1 (
    .bus_i(bus_i),
    .cfg_i(c1_cfg_r),
    .addr_i(c1_addr_r),
    .amask_i(c1_amask_r),
    .data_i(c1_data_r),
    .dmask_i(c1_dmask_r),
    .match_o(raw_m[0]),
    .fetch_mode_o(fmode[0]),
    .bad_cfg_o(bad[0])
  );

  hbm_chan_match #(.HAS_DATA(1'b0)) u_ch2 (
    .bus_i(bus_i),
    .cfg_i(c2_cfg_r),
    .addr_i(c2_addr_r),
    .amask_i(c2_amask_r),
    .data_i(hbm_pkg::RST_VAL),
    .dmask_i(hbm_pkg::RST_VAL),
    .match_o(raw_m[1]),
    .fetch_mode_o(fmode[1]),
    .bad_cfg_o(bad[1])
  );

  // a channel with an illegal setting never fires
  assign en[0] = ctrl_r[hbm_pkg::CTRL_C1_EN] && !bad[0];
  assign en[1] = ctrl_r[hbm_pkg::CTRL_C2_EN] && !bad[1];
  assign pre_cfg[0] = c1_cfg_r.pre;
  assign pre_cfg[1] = c2_cfg_r.pre;

  // fetch matches without pre wait for the instruction to retire
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      imm_ev[i] = en[i] && raw_m[i] && (!fmode[i] || pre_cfg[i]);
      pre_ev[i] = imm_ev[i] && fmode[i];
      ret_ev[i] = en[i] && pend_r[i] && ret_i.valid && ret_i.addr == pend_addr_r[i];
      cond_ev[i] = imm_ev[i] || ret_ev[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
      pend_addr_r[0] <= hbm_pkg::RST_VAL;
      pend_addr_r[1] <= hbm_pkg::RST_VAL;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!en[i] || !fmode[i] || pre_cfg[i]) begin
          pend_r[i] <= 1'b0;
        end else if (raw_m[i]) begin
          pend_r[i] <= 1'b1;
          pend_addr_r[i] <= bus_i.addr;
        end else if (ret_ev[i]) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // channel one delay count
  assign d_start = cond_ev[0] && c1_cfg_r.delay[DELAY_W-1:0] != '0;
  assign d_cancel = !en[0];

  hbm_delay #(.W(DELAY_W)) u_dly (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(d_start),
    .load_i(c1_cfg_r.delay[DELAY_W-1:0]),
    .tick_i(bus_i.valid),
    .cancel_i(d_cancel),
    .done_o(d_done),
    .busy_o(d_busy),
    .left_o(d_left)
  );

  always_comb begin
    ev[1] = cond_ev[1];
    if (c1_cfg_r.delay[DELAY_W-1:0] != '0) begin
      ev[0] = d_done && en[0];
    end else begin
      ev[0] = cond_ev[0];
    end
  end

  // sequential arming and halt decision
  always_comb begin
    if (ctrl_r[hbm_pkg::CTRL_SEQ]) begin
      halt = armed_r && ev[0];
      halt_pre = halt && pre_ev[0] && c1_cfg_r.delay == '0;
    end else begin
      halt = ev[0] || ev[1];
      halt_pre = (ev[0] && pre_ev[0] && c1_cfg_r.delay == '0) || (ev[1] && pre_ev[1]);
    end
    armed_nxt = ctrl_r[hbm_pkg::CTRL_SEQ] && (ev[1] || (armed_r && !halt));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // one pulse per cycle with a halt decision; core stops some instructions later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_req_o <= 1'b0;
      halt_pre_o <= 1'b0;
    end else begin
      halt_req_o <= halt;
      halt_pre_o <= halt_pre;
    end
  end

  // address of the cycle that last met each channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_last_r <= hbm_pkg::RST_VAL;
      c2_last_r <= hbm_pkg::RST_VAL;
    end else begin
      if (en[0] && raw_m[0]) begin
        c1_last_r <= bus_i.addr;
      end
      if (en[1] && raw_m[1]) begin
        c2_last_r <= bus_i.addr;
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  always_comb begin
    status_nxt = status_r;
    if (wr_take && adr_i == hbm_pkg::REG_STATUS && sel_i[0]) begin
      status_nxt = status_r & ~dat_i[hbm_pkg::ST_W-1:0];
    end
    status_nxt[hbm_pkg::ST_C1_HIT] = status_nxt[hbm_pkg::ST_C1_HIT] | ev[0];
    status_nxt[hbm_pkg::ST_C2_HIT] = status_nxt[hbm_pkg::ST_C2_HIT] | ev[1];
    status_nxt[hbm_pkg::ST_HALT] = status_nxt[hbm_pkg::ST_HALT] | halt;
    status_nxt[hbm_pkg::ST_CFG_ERR] = status_nxt[hbm_pkg::ST_CFG_ERR]
      | (ctrl_r[hbm_pkg::CTRL_C1_EN] && bad[0])
      | (ctrl_r[hbm_pkg::CTRL_C2_EN] && bad[1]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_nxt & irq_mask_r);
    end
  end
endmodule : hbm_break_matcher
`default_nettype wire

//--- pkg/hbm_pkg.sv
// package: register map, field layouts and carriers of the break matcher
package hbm_pkg;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_C1_ADDR = 8'h04;
  localparam logic [AW-1:0] REG_C1_AMASK = 8'h08;
  localparam logic [AW-1:0] REG_C1_DATA = 8'h0c;
  localparam logic [AW-1:0] REG_C1_DMASK = 8'h10;
  localparam logic [AW-1:0] REG_C1_CFG = 8'h14;
  localparam logic [AW-1:0] REG_C2_ADDR = 8'h18;
  localparam logic [AW-1:0] REG_C2_AMASK = 8'h1c;
  localparam logic [AW-1:0] REG_C2_CFG = 8'h20;
  localparam logic [AW-1:0] REG_STATUS = 8'h24;
  localparam logic [AW-1:0] REG_IRQ_MASK = 8'h28;
  localparam logic [AW-1:0] REG_DLY_LEFT = 8'h2c;
  localparam logic [AW-1:0] REG_C1_LAST = 8'h30;
  localparam logic [AW-1:0] REG_C2_LAST = 8'h34;
  // control bits
  localparam int unsigned CTRL_C1_EN = 0;
  localparam int unsigned CTRL_C2_EN = 1;
  localparam int unsigned CTRL_SEQ = 2;
  localparam int unsigned CTRL_W = 3;
  // status bits
  localparam int unsigned ST_C1_HIT = 0;
  localparam int unsigned ST_C2_HIT = 1;
  localparam int unsigned ST_HALT = 2;
  localparam int unsigned ST_CFG_ERR = 3;
  localparam int unsigned ST_W = 4;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam int unsigned DLY_W = 12;
  localparam int unsigned CFG_W = 21;
  // address selection, data size, direction, cycle type encodings
  localparam logic [1:0] ASEL_NONE = 2'h0;
  localparam logic [1:0] ASEL_GEN = 2'h1;
  localparam logic [1:0] ASEL_FETCH = 2'h2;
  localparam logic [1:0] DSZ_NONE = 2'h0;
  localparam logic [1:0] DSZ_BYTE = 2'h1;
  localparam logic [1:0] DSZ_WORD = 2'h2;
  localparam logic [1:0] DSZ_LONG = 2'h3;
  localparam logic [1:0] DIR_ANY = 2'h0;
  localparam logic [1:0] DIR_READ = 2'h1;
  localparam logic [1:0] DIR_WRITE = 2'h2;
  localparam logic [1:0] CT_ALL = 2'h0;
  localparam logic [1:0] CT_EXEC = 2'h1;
  localparam logic [1:0] CT_DMA = 2'h2;
  typedef enum logic [1:0] {KIND_FETCH, KIND_EXEC, KIND_DMA} hbm_kind_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} hbm_size_e;
  // channel configuration word, bit 0 upward: asel, pre, dsz, dir, ctype, delay
  typedef struct packed {
    logic [DLY_W-1:0] delay;
    logic [1:0] ctype;
    logic [1:0] dir;
    logic [1:0] dsz;
    logic pre;
    logic [1:0] asel;
  } hbm_cfg_s;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic wr;
    hbm_size_e size;
    hbm_kind_e kind;
  } hbm_bus_s;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } hbm_ret_s;
  function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    masked_eq = ~|((a ^ b) & ~m);
  endfunction : masked_eq
endpackage : hbm_pkg

//--- verilog/hbm_chan_match.sv
// one break channel: compares a bus cycle with its programmed sub-conditions
`timescale 1ns/1ps
`default_nettype none
module hbm_chan_match #(
  parameter bit HAS_DATA = 1'b1
) (
  input wire hbm_pkg::hbm_bus_s bus_i,
  input wire hbm_pkg::hbm_cfg_s cfg_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] amask_i,
  input wire logic [31:0] data_i,
  input wire logic [31:0] dmask_i,
  output logic match_o,
  output logic fetch_mode_o,
  output logic bad_cfg_o
);
  logic addr_ok, data_ok, dir_ok, ct_ok, fetch_ok;
  logic [31:0] szmask;
  logic use_data;
  always_comb begin
    use_data = HAS_DATA && (cfg_i.dsz != hbm_pkg::DSZ_NONE);
    fetch_mode_o = (cfg_i.asel == hbm_pkg::ASEL_FETCH);
    addr_ok = (cfg_i.asel == hbm_pkg::ASEL_NONE) || hbm_pkg::masked_eq(bus_i.addr, addr_i, amask_i);
    szmask = 32'hffff_ffff;
    if (cfg_i.dsz == hbm_pkg::DSZ_BYTE) begin
      szmask = 32'h0000_00ff;
    end else if (cfg_i.dsz == hbm_pkg::DSZ_WORD) begin
      szmask = 32'h0000_ffff;
    end
    data_ok = 1'b1;
    if (use_data) begin
      data_ok = (bus_i.kind != hbm_pkg::KIND_FETCH)
        && (bus_i.size == hbm_pkg::hbm_size_e'(cfg_i.dsz - 2'h1))
        && hbm_pkg::masked_eq(bus_i.data & szmask, data_i & szmask, dmask_i | ~szmask);
    end
    dir_ok = (cfg_i.dir == hbm_pkg::DIR_ANY) || ((cfg_i.dir == hbm_pkg::DIR_WRITE) == bus_i.wr);
    ct_ok = (cfg_i.ctype == hbm_pkg::CT_ALL)
      || ((cfg_i.ctype == hbm_pkg::CT_EXEC) && (bus_i.kind == hbm_pkg::KIND_EXEC))
      || ((cfg_i.ctype == hbm_pkg::CT_DMA) && (bus_i.kind == hbm_pkg::KIND_DMA));
    fetch_ok = bus_i.kind == hbm_pkg::KIND_FETCH;
    // fetch mode keeps only the address test; the delay is applied outside
    if (fetch_mode_o) begin
      match_o = bus_i.valid && fetch_ok && addr_ok;
    end else begin
      match_o = bus_i.valid && addr_ok && data_ok && dir_ok && ct_ok;
    end
    bad_cfg_o = (cfg_i.asel == 2'h3) || (cfg_i.dir == 2'h3) || (cfg_i.ctype == 2'h3);
    if (use_data && !fetch_mode_o) begin
      if (cfg_i.dsz == hbm_pkg::DSZ_LONG && addr_i[1:0] != 2'h0) begin
        bad_cfg_o = 1'b1;
      end else if (cfg_i.dsz == hbm_pkg::DSZ_WORD && addr_i[0]) begin
        bad_cfg_o = 1'b1;
      end
    end
  end
endmodule : hbm_chan_match
`default_nettype wire

//--- verilog/hbm_delay.sv
// delay counter: counts further bus cycles after a channel condition is met
`timescale 1ns/1ps
`default_nettype none
module hbm_delay #(
  parameter int unsigned W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [W-1:0] load_i,
  input wire logic tick_i,
  input wire logic cancel_i,
  output logic done_o,
  output logic busy_o,
  output logic [W-1:0] left_o
);
  if (W < 1 || W > 16) begin : g_chk
    $error("hbm_delay: W must be 1 to 16");
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || cancel_i) begin
      busy_o <= 1'b0;
      left_o <= '0;
    end else if (busy_o && tick_i) begin
      left_o <= left_o - 1'b1;
      busy_o <= (left_o != {{(W-1){1'b0}}, 1'b1});
    end else if (!busy_o && start_i && load_i != '0) begin
      busy_o <= 1'b1;
      left_o <= load_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || cancel_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && tick_i && (left_o == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule : hbm_delay
`default_nettype wire

//--- tb/hbm_bus_model.sv
// partner model: core and dma bus cycles plus retirement reports
`timescale 1ns/1ps
`default_nettype none
module hbm_bus_model (
  input wire logic clk_i,
  output var hbm_pkg::hbm_bus_s bus_o,
  output var hbm_pkg::hbm_ret_s ret_o
);
  initial begin
    bus_o = '0;
    ret_o = '0;
  end
  // one bus cycle, then idle with inverted leftovers
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic w, input hbm_pkg::hbm_size_e s,
                    input hbm_pkg::hbm_kind_e k);
    @(posedge clk_i);
    bus_o <= '{1'b1, a, d, w, s, k};
    @(posedge clk_i);
    bus_o <= '{1'b0, ~a, ~d, ~w, s, k};
  endtask : op
  // instruction at a has finished executing
  task automatic retire(input logic [31:0] a);
    @(posedge clk_i);
    ret_o <= '{1'b1, a};
    @(posedge clk_i);
    ret_o <= '{1'b0, ~a};
  endtask : retire
endmodule : hbm_bus_model
`default_nettype wire

//--- tb/hbm_break_matcher_monitor.sv
// checker: bus handshake and halt request relations of the break matcher
`timescale 1ns/1ps
`default_nettype none
module hbm_break_matcher_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire hbm_pkg::hbm_bus_s bus_i,
  input wire hbm_pkg::hbm_ret_s ret_i,
  input wire logic halt_req_o,
  input wire logic halt_pre_o,
  input wire logic irq_o
);
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence halt_s;
    halt_req_o ##1 !halt_req_o;
  endsequence
  AST_WB_ANSWER: assert property (req_s |=> ack_o ^ err_o)
    else $error("bus request not answered next cycle");
  AST_WB_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_WB_ERR_CAUSE: assert property (err_o |-> $past(cyc_i && stb_i) && !ack_o)
    else $error("error without request");
  AST_WB_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  AST_HALT_PULSE: assert property (halt_req_o |-> halt_s)
    else $error("halt request longer than one cycle");
  AST_HALT_CAUSE: assert property (halt_req_o |-> $past(bus_i.valid) || $past(bus_i.valid, 2) || $past(ret_i.valid))
    else $error("halt request without bus cycle");
  AST_PRE_TIED: assert property (halt_pre_o |-> halt_req_o && $past(bus_i.valid))
    else $error("pre flag without halt");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(cyc_i && we_i, 1) || $past(cyc_i && we_i, 2))
    else $error("interrupt dropped without write");
endmodule : hbm_break_matcher_monitor
bind hbm_break_matcher hbm_break_matcher_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i,
  .dat_i, .dat_o, .ack_o, .err_o, .bus_i, .ret_i, .halt_req_o, .halt_pre_o, .irq_o);
`default_nettype wire

//--- tb/hbm_break_matcher_tb.sv
// testbench: registers, channel matching, sequential mode and interrupt
`timescale 1ns/1ps
`default_nettype none
module hbm_break_matcher_tb;
  localparam logic [1:0] GEN = hbm_pkg::ASEL_GEN;
  localparam logic [1:0] FET = hbm_pkg::ASEL_FETCH;
  localparam hbm_pkg::hbm_size_e SB = hbm_pkg::SZ_BYTE;
  localparam hbm_pkg::hbm_size_e SL = hbm_pkg::SZ_LONG;
  localparam hbm_pkg::hbm_kind_e KF = hbm_pkg::KIND_FETCH;
  localparam hbm_pkg::hbm_kind_e KE = hbm_pkg::KIND_EXEC;
  logic clk_i = 1'b0;
  logic rst_i, cyc_i, stb_i, we_i, ack_o, err_o, halt_req_o, halt_pre_o, irq_o, e;
  logic [3:0] sel_i;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  hbm_pkg::hbm_bus_s bus_i;
  hbm_pkg::hbm_ret_s ret_i;
  logic [31:0] halt_cnt = 32'h0;
  logic [31:0] pre_cnt = 32'h0;
  logic [31:0] base = 32'h0;
  logic [31:0] pre_base = 32'h0;
  int fail_count = 0;
  int comparisons = 0;
  int ticks = 0;
  always #50 clk_i = ~clk_i;
  hbm_break_matcher #(.DELAY_W(12)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i,
    .dat_o, .ack_o, .err_o, .bus_i, .ret_i, .halt_req_o, .halt_pre_o, .irq_o);
  hbm_bus_model u_bm (.clk_i, .bus_o(bus_i), .ret_o(ret_i));
  always @(posedge clk_i) begin
    if (halt_req_o === 1'b1) begin
      halt_cnt <= halt_cnt + 32'h1;
    end
    if (halt_pre_o === 1'b1) begin
      pre_cnt <= pre_cnt + 32'h1;
    end
  end
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // halt and pre pulses seen since the last call
  task automatic hits(input logic [31:0] h, input logic [31:0] p);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk(halt_cnt - base, h);
    chk(pre_cnt - pre_base, p);
    base = halt_cnt;
    pre_base = pre_cnt;
  endtask : hits
  function automatic logic [31:0] mk(input logic [1:0] as, input logic pre, input logic [1:0] dz,
                                    input logic [1:0] dr, input logic [1:0] ct, input logic [11:0] dly);
    mk = {11'h0, dly, ct, dr, dz, pre, as};
  endfunction : mk
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(hbm_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(8'h3c, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    wb(hbm_pkg::REG_DLY_LEFT, 1'b1, 32'hfff);
    wb(hbm_pkg::REG_DLY_LEFT, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(hbm_pkg::REG_C1_ADDR, 1'b1, 32'h100);
    wb(hbm_pkg::REG_C1_ADDR, 1'b0, 32'h0);
    chk(q, 32'h100);
    $display("test registers done");
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h0, 2'h0, 2'h0, 12'h0));
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KE);
    hits(0, 0);
    wb(hbm_pkg::REG_CTRL, 1'b1, 32'h1);
    u_bm.op(32'h104, 32'h0, 1'b0, SL, KE);
    hits(0, 0);
    for (int k = 0; k < 3; k++) begin
      u_bm.op(32'h100, 32'h0, 1'b0, SL, hbm_pkg::hbm_kind_e'(2'(k)));
      hits(1, 0);
    end
    wb(hbm_pkg::REG_C1_AMASK, 1'b1, 32'hf);
    u_bm.op(32'h10f, 32'h0, 1'b1, SL, KE);
    hits(1, 0);
    wb(hbm_pkg::REG_C1_AMASK, 1'b1, 32'h0);
    $display("test address done");
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(FET, 1'b1, 2'h1, 2'h2, 2'h2, 12'h0));
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KE);
    hits(0, 0);
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KF);
    hits(1, 1);
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(FET, 1'b0, 2'h0, 2'h0, 2'h0, 12'h0));
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KF);
    hits(0, 0);
    u_bm.retire(32'h100);
    hits(1, 0);
    $display("test fetch done");
    wb(hbm_pkg::REG_C1_ADDR, 1'b1, 32'h200);
    wb(hbm_pkg::REG_C1_DATA, 1'b1, 32'h55);
    wb(hbm_pkg::REG_C1_DMASK, 1'b1, 32'h1);
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h1, 2'h0, 2'h0, 12'h0));
    u_bm.op(32'h200, 32'h54, 1'b0, SB, KE);
    hits(1, 0);
    u_bm.op(32'h200, 32'h55, 1'b0, hbm_pkg::SZ_WORD, KE);
    hits(0, 0);
    u_bm.op(32'h200, 32'h55, 1'b0, SB, KF);
    hits(0, 0);
    u_bm.op(32'h200, 32'h57, 1'b1, SB, hbm_pkg::KIND_DMA);
    hits(0, 0);
    wb(hbm_pkg::REG_C1_ADDR, 1'b1, 32'h202);
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h3, 2'h0, 2'h0, 12'h0));
    u_bm.op(32'h202, 32'h55, 1'b0, SL, KE);
    hits(0, 0);
    wb(hbm_pkg::REG_STATUS, 1'b0, 32'h0);
    chk(q & 32'h8, 32'h8);
    $display("test data done");
    wb(hbm_pkg::REG_C1_ADDR, 1'b1, 32'h100);
    for (int i = 0; i < 4; i++) begin
      wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h0, i[1] ? 2'h2 : 2'h1, 2'h0, 12'h0));
      u_bm.op(32'h100, 32'h0, i[0], SL, KE);
      hits({31'h0, i[0] == i[1]}, 0);
    end
    for (int i = 0; i < 6; i++) begin
      wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h0, 2'h0, i < 3 ? 2'h1 : 2'h2, 12'h0));
      u_bm.op(32'h100, 32'h0, 1'b0, SL, hbm_pkg::hbm_kind_e'(2'(i % 3)));
      hits({31'h0, i == 1 || i == 5}, 0);
    end
    $display("test direction and type done");
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h0, 2'h2, 2'h0, 12'h3));
    u_bm.op(32'h100, 32'h0, 1'b1, SL, KE);
    repeat (2) u_bm.op(32'h500, 32'h0, 1'b0, SL, KE);
    hits(0, 0);
    wb(hbm_pkg::REG_DLY_LEFT, 1'b0, 32'h0);
    chk(q, 32'h1);
    u_bm.op(32'h500, 32'h0, 1'b0, SL, KF);
    hits(1, 0);
    $display("test delay done");
    wb(hbm_pkg::REG_CTRL, 1'b1, 32'h2);
    wb(hbm_pkg::REG_C2_ADDR, 1'b1, 32'h300);
    wb(hbm_pkg::REG_C2_CFG, 1'b1, mk(FET, 1'b1, 2'h0, 2'h2, 2'h2, 12'h0));
    u_bm.op(32'h300, 32'h0, 1'b0, SL, KF);
    hits(1, 1);
    wb(hbm_pkg::REG_C2_CFG, 1'b1, mk(GEN, 1'b0, 2'h0, 2'h0, 2'h0, 12'h0));
    wb(hbm_pkg::REG_C1_CFG, 1'b1, mk(GEN, 1'b0, 2'h0, 2'h0, 2'h0, 12'h0));
    wb(hbm_pkg::REG_CTRL, 1'b1, 32'h7);
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KE);
    u_bm.op(32'h300, 32'h0, 1'b0, SL, KE);
    hits(0, 0);
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KE);
    hits(1, 0);
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KE);
    hits(0, 0);
    $display("test sequential done");
    wb(hbm_pkg::REG_CTRL, 1'b1, 32'h1);
    wb(hbm_pkg::REG_STATUS, 1'b1, 32'hf);
    wb(hbm_pkg::REG_IRQ_MASK, 1'b1, 32'h2);
    u_bm.op(32'h100, 32'h0, 1'b0, SL, KE);
    hits(1, 0);
    chk({31'h0, irq_o}, 32'h0);
    wb(hbm_pkg::REG_IRQ_MASK, 1'b1, 32'h1);
    hits(0, 0);
    chk({31'h0, irq_o}, 32'h1);
    wb(hbm_pkg::REG_STATUS, 1'b1, 32'h1);
    hits(0, 0);
    chk({31'h0, irq_o}, 32'h0);
    wb(hbm_pkg::REG_STATUS, 1'b0, 32'h0);
    chk(q, 32'h4);
    $display("test interrupt done");
    print_verdict();
  end
endmodule : hbm_break_matcher_tb
`default_nettype wire
